/* shared/bdr_pkg.sv */
// constants and types for the breakpoint debug register unit
// Functional notes
// - 64-bit registers; outside 64-bit mode top half written 0, not read
// - In 64-bit mode all 64 bits are read and written; size prefixes ignored
// - Access only from ring 0; other rings get a protection fault
// - Location registers accept any address, no canonical check
// - Numbers 4, 5 alias status, control; invalid opcode if extensions on
// - Status bits 15:13 are never cleared by hardware; software clears them
// - Breakpoint or guard events rewrite status bits 3-0 from enabled hits
// - Status bit 13 set on register access while the guard is on
// - Status bit 14 set on single-step trap; other bits may join it
// - Status bit 15 set on switch to a task with trap bit set
// - Status reserved bits read fixed; 64-bit upper-half ones fault
// - Control even bits enable per task; cleared on hardware task switch
// - Control odd bits enable in any task; never cleared by hardware
// - Control bits 8 and 9 are stored and have no effect
// - Guard on: any ring-0 move that is not an invalid opcode traps first and sets status bit 13
// - Guard bit cleared on entry to the debug trap handler
// - Access type field picks execute, write, I/O, or read/write
// - Size field sets the compared address range
// - Four independent address-match conditions, one per location register
// - Size codes 1, 2, 8, 4 bytes; covered low bits masked
// - Hit when any accessed byte falls within the selected range
// - Control reserved bits read fixed; 64-bit upper-half ones fault
package bdr_pkg;
  localparam int BDR_XLEN  = 64;
  localparam int BDR_HALF  = 32;
  localparam int BDR_SLOTS = 4;
  localparam int BDR_SIZEW = 4;

  // register numbers
  localparam logic [2:0] BDR_NUM_STATUS = 3'h6;
  localparam logic [2:0] BDR_NUM_CTRL   = 3'h7;
  localparam logic [2:0] BDR_NUM_AL_ST  = 3'h4;
  localparam logic [2:0] BDR_NUM_AL_CT  = 3'h5;
  localparam logic [2:0] BDR_ALIAS_OR   = 3'h2;
  localparam logic [1:0] BDR_RING0      = 2'h0;

  // status layout
  localparam int BDR_ST_GHIT  = 13;
  localparam int BDR_ST_SSTEP = 14;
  localparam int BDR_ST_TSW   = 15;
  localparam logic [31:0] BDR_ST_ONES = 32'hFFFF0FF0;

  // control layout
  localparam int BDR_CT_GUARD    = 13;
  localparam int BDR_CT_TYPE_LSB = 16;
  localparam int BDR_CT_SIZE_LSB = 18;
  localparam int BDR_CT_STEP     = 4;
  localparam logic [31:0] BDR_CT_ONES   = 32'h00000400;
  localparam logic [31:0] BDR_CT_WMASK  = 32'hFFFF23FF;
  localparam logic [31:0] BDR_CT_LOCAL  = 32'h00000055;
  localparam logic [31:0] BDR_CT_GLOBAL = 32'h000000AA;
  localparam logic [31:0] BDR_CT_GDBIT  = 32'h00002000;

  // access type field
  localparam logic [1:0] BDR_TY_EXEC  = 2'h0;
  localparam logic [1:0] BDR_TY_WRITE = 2'h1;
  localparam logic [1:0] BDR_TY_IO    = 2'h2;
  localparam logic [1:0] BDR_TY_RW    = 2'h3;

  // size field
  localparam logic [1:0] BDR_SZ_1 = 2'h0;
  localparam logic [1:0] BDR_SZ_2 = 2'h1;
  localparam logic [1:0] BDR_SZ_8 = 2'h2;
  localparam logic [1:0] BDR_SZ_4 = 2'h3;
  localparam logic [63:0] BDR_MASK_1 = 64'h0;
  localparam logic [63:0] BDR_MASK_2 = 64'h1;
  localparam logic [63:0] BDR_MASK_4 = 64'h3;
  localparam logic [63:0] BDR_MASK_8 = 64'h7;
  localparam logic [63:0] BDR_ONE64  = 64'h1;

  typedef enum logic [1:0] {
    BDR_K_FETCH = 2'b00,
    BDR_K_WRITE = 2'b01,
    BDR_K_IO    = 2'b10,
    BDR_K_READ  = 2'b11
  } bdr_kind_e;
endpackage : bdr_pkg

/* shared/bdr_ref_if.sv */
// reference broadcast from unit to address comparators
`timescale 1ns/100ps
`default_nettype none
interface bdr_ref_if;
  import bdr_pkg::*;
  logic                 refValid;
  bdr_kind_e            refKind;
  logic [BDR_XLEN-1:0]  refAddr;
  logic [BDR_SIZEW-1:0] refSize;
  logic                 extOn;
  modport drive (output refValid, refKind, refAddr, refSize, extOn);
  modport sense (input refValid, refKind, refAddr, refSize, extOn);
endinterface : bdr_ref_if
`default_nettype wire

/* src/bdr_match.sv */
// one address-match comparator
`timescale 1ns/100ps
`default_nettype none
module bdr_match
  import bdr_pkg::*;
(
  bdr_ref_if.sense           refBus,     // reference under test
  input  wire logic [63:0]   bpAddr,     // location register
  input  wire logic [1:0]    typeField,  // access type field
  input  wire logic [1:0]    sizeField,  // match size field
  output logic               hit         // raw condition, not enable-gated
);
  logic [63:0] lenMask;
  logic [63:0] bpLo;
  logic [63:0] bpHi;
  logic [63:0] accHi;
  logic        inRange;
  logic        typeOk;

  // low bits covered by the size are masked
  assign lenMask = (sizeField == BDR_SZ_1) ? BDR_MASK_1 :
                   (sizeField == BDR_SZ_2) ? BDR_MASK_2 :
                   (sizeField == BDR_SZ_4) ? BDR_MASK_4 :
                                             BDR_MASK_8;
  assign bpLo  = bpAddr & ~lenMask;
  assign bpHi  = bpAddr | lenMask;
  assign accHi = refBus.refAddr
               + {{(BDR_XLEN-BDR_SIZEW){1'b0}}, refBus.refSize}
               - BDR_ONE64;
  // any accessed byte inside the range
  assign inRange = (refBus.refAddr <= bpHi) && (accHi >= bpLo);

  assign typeOk =
    (typeField == BDR_TY_EXEC)  ? (refBus.refKind == BDR_K_FETCH) :
    (typeField == BDR_TY_WRITE) ? (refBus.refKind == BDR_K_WRITE) :
    (typeField == BDR_TY_IO)    ? (refBus.refKind == BDR_K_IO)
                                  && refBus.extOn :
    (refBus.refKind == BDR_K_WRITE) ||
    (refBus.refKind == BDR_K_READ);

  assign hit = refBus.refValid && typeOk && inRange;
endmodule : bdr_match
`default_nettype wire

/* src/bdr_unit.sv */
// breakpoint debug register unit top
`timescale 1ns/100ps
`default_nettype none
module bdr_unit
  import bdr_pkg::*;
(
  input  wire logic          mclk,         // core clock
  input  wire logic          rst,          // sync reset, high
  // register move port
  input  wire logic          regReq,       // move request pulse
  input  wire logic          regWrite,     // 1 write, 0 read
  input  wire logic [2:0]    regNum,       // register number 0..7
  input  wire logic [63:0]   regWrData,    // write operand
  output logic [63:0]        regRdData,    // read result
  output logic               regDone,      // move answered
  output logic               faultGp,      // protection fault
  output logic               faultUd,      // invalid opcode fault
  // core state
  input  wire logic          mode64,       // 64-bit mode
  input  wire logic [1:0]    privRing,     // current privilege ring
  input  wire logic          debugExtOn,   // debug extensions on
  // references
  input  wire logic          refValid,     // reference this cycle
  input  wire bdr_kind_e     refKind,      // reference kind
  input  wire logic [63:0]   refAddr,      // first byte address
  input  wire logic [3:0]    refSize,      // bytes, 1..8
  // exception events
  input  wire logic          stepEvent,    // single-step trap flag trap
  input  wire logic          taskSwitch,   // hardware task switch
  input  wire logic          taskTrapBit,  // new task trap bit
  input  wire logic          handlerEntry, // debug handler entered
  output logic               debugTrapReq  // debug trap request
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [63:0] locQ [BDR_SLOTS];
  logic [3:0]  hitQ;
  logic        guardHitQ;
  logic        stepFlagQ;
  logic        taskFlagQ;
  logic [31:0] ctrlQ;
  logic [31:0] ctrlD;
  logic [3:0]  hitD;
  logic        guardHitD;
  logic        stepFlagD;
  logic        taskFlagD;
  logic [63:0] rdDataQ;
  logic        doneQ;
  logic        gpQ;
  logic        udQ;
  logic        trapQ;

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  bdr_ref_if refBus ();

  assign refBus.refValid = refValid;
  assign refBus.refKind  = refKind;
  assign refBus.refAddr  = refAddr;
  assign refBus.refSize  = refSize;
  assign refBus.extOn    = debugExtOn;

  logic [3:0] hitVec;
  logic [3:0] enVec;
  logic [3:0] enabledHit;
  logic       bpEvent;

  genvar gi;
  generate
    for (gi = 0; gi < BDR_SLOTS; gi++) begin : g_slot
      bdr_match u_match (
        .refBus    (refBus),
        .bpAddr    (locQ[gi]),
        .typeField (ctrlQ[BDR_CT_TYPE_LSB+BDR_CT_STEP*gi +: 2]),
        .sizeField (ctrlQ[BDR_CT_SIZE_LSB+BDR_CT_STEP*gi +: 2]),
        .hit       (hitVec[gi])
      );
      // local or global enable
      assign enVec[gi] = ctrlQ[2*gi] | ctrlQ[2*gi+1];
    end
  endgenerate

  assign enabledHit = hitVec & enVec;
  assign bpEvent    = |enabledHit;

  // ----------------------------------------------------------------
  // move decode
  // ----------------------------------------------------------------
  logic        ring0;
  logic        aliasNum;
  logic [2:0]  effNum;
  logic        udHit;
  logic        gpPriv;
  logic        guardTrap;
  logic        upperBad;
  logic        gpUpper;
  logic        doAccess;
  logic        stWrite;
  logic        ctWrite;
  logic        locWrite;
  logic [63:0] wrVal;

  assign ring0    = (privRing == BDR_RING0);
  assign aliasNum = (regNum == BDR_NUM_AL_ST) ||
                    (regNum == BDR_NUM_AL_CT);
  assign effNum   = aliasNum ? (regNum | BDR_ALIAS_OR) : regNum;

  assign gpPriv    = regReq && !ring0;
  assign udHit     = regReq && ring0 && aliasNum && debugExtOn;
  // guard traps ahead of the move itself
  assign guardTrap = regReq && ring0 && !udHit
                     && ctrlQ[BDR_CT_GUARD];
  assign upperBad  = mode64 && regWrite
                     && (|regWrData[BDR_XLEN-1:BDR_HALF])
                     && ((effNum == BDR_NUM_STATUS) ||
                         (effNum == BDR_NUM_CTRL));
  assign gpUpper   = regReq && ring0 && !udHit && !guardTrap
                     && upperBad;
  assign doAccess  = regReq && ring0 && !udHit && !guardTrap
                     && !upperBad;

  assign stWrite  = doAccess && regWrite && (effNum == BDR_NUM_STATUS);
  assign ctWrite  = doAccess && regWrite && (effNum == BDR_NUM_CTRL);
  assign locWrite = doAccess && regWrite && !effNum[2];

  // top half zeroed outside 64-bit mode
  assign wrVal = mode64 ? regWrData
               : {{BDR_HALF{1'b0}}, regWrData[BDR_HALF-1:0]};

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [63:0] statusRd;
  logic [63:0] ctrlRd;
  logic [63:0] rdSel;
  logic [63:0] rdVal;

  assign statusRd = {{BDR_HALF{1'b0}},
                     BDR_ST_ONES | {16'h0, taskFlagQ, stepFlagQ,
                                    guardHitQ, 9'h0, hitQ}};
  assign ctrlRd   = {{BDR_HALF{1'b0}},
                     (ctrlQ & BDR_CT_WMASK) | BDR_CT_ONES};
  assign rdSel = !effNum[2] ? locQ[effNum[1:0]] :
                 effNum[0]  ? ctrlRd : statusRd;
  assign rdVal = mode64 ? rdSel
               : {{BDR_HALF{1'b0}}, rdSel[BDR_HALF-1:0]};

  // ----------------------------------------------------------------
  // next status and control
  // ----------------------------------------------------------------
  logic tsTrap;
  logic trapEvent;

  assign tsTrap    = taskSwitch && taskTrapBit;
  assign trapEvent = bpEvent || stepEvent || tsTrap || guardTrap;

  // hardware events win over a same-cycle software write
  assign hitD = (bpEvent || guardTrap) ? enabledHit
              : stWrite ? wrVal[3:0] : hitQ;
  assign guardHitD = guardTrap ||
                     (stWrite ? wrVal[BDR_ST_GHIT] : guardHitQ);
  assign stepFlagD = stepEvent ||
                     (stWrite ? wrVal[BDR_ST_SSTEP] : stepFlagQ);
  assign taskFlagD = tsTrap ||
                     (stWrite ? wrVal[BDR_ST_TSW] : taskFlagQ);

  // bits 8 and 9 kept but read by nothing else
  assign ctrlD = ((ctWrite ? (wrVal[BDR_HALF-1:0] & BDR_CT_WMASK)
                           : ctrlQ)
                  & ~(taskSwitch ? BDR_CT_LOCAL : 32'h0))
                  & ~(handlerEntry ? BDR_CT_GDBIT : 32'h0);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      hitQ  <= 4'h0;
      guardHitQ <= 1'b0;
      stepFlagQ <= 1'b0;
      taskFlagQ <= 1'b0;
      ctrlQ <= 32'h0;
    end else begin
      hitQ  <= hitD;
      guardHitQ <= guardHitD;
      stepFlagQ <= stepFlagD;
      taskFlagQ <= taskFlagD;
      ctrlQ <= ctrlD;
    end
  end

  // any value accepted, no canonical check
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < BDR_SLOTS; i++) begin
        locQ[i] <= 64'h0;
      end
    end else if (locWrite) begin
      locQ[effNum[1:0]] <= wrVal;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdDataQ <= 64'h0;
      doneQ   <= 1'b0;
      gpQ     <= 1'b0;
      udQ     <= 1'b0;
      trapQ   <= 1'b0;
    end else begin
      rdDataQ <= (doAccess && !regWrite) ? rdVal : 64'h0;
      doneQ   <= regReq;
      gpQ     <= gpPriv || gpUpper;
      udQ     <= udHit;
      trapQ   <= trapEvent;
    end
  end

  assign regRdData    = rdDataQ;
  assign regDone      = doneQ;
  assign faultGp      = gpQ;
  assign faultUd      = udQ;
  assign debugTrapReq = trapQ;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sGuardMove;
    regReq && ring0 && !udHit && ctrlQ[BDR_CT_GUARD];
  endsequence

  sequence sGuardSeen;
    debugTrapReq && guardHitQ && !faultGp && regRdData == 64'h0;
  endsequence

  sequence sLowRead;
    regReq && !regWrite && !mode64 && ring0;
  endsequence

  sequence sCtrlRead;
    doAccess && !regWrite && effNum == BDR_NUM_CTRL;
  endsequence

  sequence sStatusRead;
    doAccess && !regWrite && effNum == BDR_NUM_STATUS;
  endsequence

  sequence sWideRead;
    doAccess && !regWrite && mode64 && !effNum[2];
  endsequence

  chk_ring_fault: assert property (
    regReq && privRing != BDR_RING0 |=> faultGp && regDone && !faultUd)
    else $error("move outside ring 0 did not fault");

  chk_read_upper: assert property (
    sLowRead |=> regRdData[BDR_XLEN-1:BDR_HALF] == 32'h0)
    else $error("upper half seen outside 64-bit mode");

  chk_alias_fault: assert property (
    regReq && ring0 && aliasNum && debugExtOn |=> faultUd && !faultGp)
    else $error("alias number did not give invalid opcode");

  chk_guard_trap: assert property (
    sGuardMove |=> sGuardSeen)
    else $error("guarded move did not trap with status set");

  chk_step_flag: assert property (
    stepEvent |=> stepFlagQ && debugTrapReq)
    else $error("single step not recorded");

  chk_task_flag: assert property (
    tsTrap |=> taskFlagQ && debugTrapReq && (ctrlQ & BDR_CT_LOCAL) == 32'h0)
    else $error("task switch trap not recorded");

  chk_global_keep: assert property (
    !ctWrite |=> (ctrlQ & BDR_CT_GLOBAL) == ($past(ctrlQ) & BDR_CT_GLOBAL))
    else $error("global enable changed without a write");

  chk_sticky_bits: assert property (
    !stWrite |=> ({taskFlagQ, stepFlagQ, guardHitQ}
                  & $past({taskFlagQ, stepFlagQ, guardHitQ}))
                 == $past({taskFlagQ, stepFlagQ, guardHitQ}))
    else $error("sticky status bit cleared by hardware");

  chk_hit_rewrite: assert property (
    bpEvent |=> hitQ == $past(enabledHit) && debugTrapReq)
    else $error("hit flags not rewritten on breakpoint");

  chk_guard_clear: assert property (
    handlerEntry |=> !ctrlQ[BDR_CT_GUARD])
    else $error("guard not cleared on handler entry");

  chk_upper_fault: assert property (
    regReq && ring0 && !udHit && !ctrlQ[BDR_CT_GUARD] && upperBad
    |=> faultGp ##1 !faultGp || regReq)
    else $error("upper-half write did not fault");

  chk_priv_nodata: assert property (
    gpPriv |=> regRdData == 64'h0 && !faultUd)
    else $error("refused move returned data");

  chk_local_clear: assert property (
    taskSwitch |=> (ctrlQ & BDR_CT_LOCAL) == 32'h0)
    else $error("local enables survived a task switch");

  chk_guard_flag: assert property (
    guardTrap |=> guardHitQ && regDone)
    else $error("guard hit flag not set");

  chk_guard_nowrite: assert property (
    guardTrap && regWrite && !effNum[2]
    |=> locQ[$past(effNum[1:0])] == $past(locQ[effNum[1:0]]))
    else $error("guarded move still wrote a location");

  chk_loc_write: assert property (
    locWrite |=> locQ[$past(effNum[1:0])] == $past(wrVal))
    else $error("location write not stored as given");

  chk_low_write: assert property (
    locWrite && !mode64
    |=> locQ[$past(effNum[1:0])][BDR_XLEN-1:BDR_HALF] == 32'h0)
    else $error("upper half kept outside 64-bit mode");

  chk_wide_read: assert property (
    sWideRead |=> regRdData == $past(locQ[effNum[1:0]]))
    else $error("full-width location read wrong");

  chk_ctrl_fixed: assert property (
    sCtrlRead |=> (regRdData[BDR_HALF-1:0] & ~BDR_CT_WMASK) == BDR_CT_ONES)
    else $error("control reserved bits read wrong");

  chk_status_fixed: assert property (
    sStatusRead |=> (regRdData[BDR_HALF-1:0] & BDR_ST_ONES) == BDR_ST_ONES)
    else $error("status reserved ones missing");

  chk_upper_keep: assert property (
    gpUpper && effNum == BDR_NUM_CTRL && !taskSwitch && !handlerEntry
    |=> $stable(ctrlQ))
    else $error("faulted control write changed the register");

endmodule : bdr_unit
`default_nettype wire

/* tb/bdr_core_model.sv */
// core pipeline model issuing references and events
`timescale 1ns/100ps
`default_nettype none
module bdr_core_model
  import bdr_pkg::*;
(
  input  wire logic   mclk,         // core clock
  input  wire logic   debugTrapReq, // trap request from unit
  output logic        refValid,     // reference strobe
  output bdr_kind_e   refKind,      // reference kind
  output logic [63:0] refAddr,      // first byte address
  output logic [3:0]  refSize,      // byte count 1..8
  output logic [3:0]  evt           // handler, trap bit, switch, step
);
  int trapCount = 0;
  initial begin
    refValid = 1'b0;
    refKind = BDR_K_FETCH;
    refAddr = 64'h0;
    refSize = 4'h1;
    evt = 4'h0;
  end
  always @(posedge mclk) begin
    if (debugTrapReq === 1'b1) trapCount++;
  end
  // one-cycle request; address scrambled once released
  task automatic issue(input bdr_kind_e k, input logic [63:0] a,
                       input logic [3:0] s, input logic [3:0] e);
    @(posedge mclk);
    #1;
    refValid = (s != 4'h0);
    refKind = k;
    refAddr = a;
    refSize = (s != 4'h0) ? s : 4'h1;
    evt = e;
    @(posedge mclk);
    #1;
    refValid = 1'b0;
    refAddr = ~a;
    evt = 4'h0;
    @(posedge mclk);
    #1;
  endtask : issue
endmodule : bdr_core_model
`default_nettype wire

/* tb/test_breakpoint_debug_register_unit.sv */
// self-checking bench for the debug register unit
`timescale 1ns/100ps
`default_nettype none
module test_breakpoint_debug_register_unit
  import bdr_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, regReq = 1'b0, regWrite = 1'b0;
  logic        mode64 = 1'b1, debugExtOn = 1'b0, dn, gp, ud;
  logic [2:0]  regNum = 3'h0;
  logic [1:0]  privRing = 2'h0;
  logic [63:0] regWrData = 64'h0, regRdData, refAddr, rd;
  logic        regDone, faultGp, faultUd, debugTrapReq, refValid;
  bdr_kind_e   refKind;
  logic [3:0]  refSize, evt;
  int          mismatches = 0, testsRun = 0;
  bdr_kind_e   kTab [8] = '{BDR_K_FETCH, BDR_K_READ, BDR_K_WRITE,
    BDR_K_READ, BDR_K_IO, BDR_K_IO, BDR_K_READ, BDR_K_WRITE};
  logic [63:0] mTab [4] = '{64'h0, 64'h1, 64'h7, 64'h3};

  always #2 mclk = ~mclk;

  bdr_core_model core (.mclk(mclk), .debugTrapReq(debugTrapReq),
    .refValid(refValid), .refKind(refKind), .refAddr(refAddr),
    .refSize(refSize), .evt(evt));

  bdr_unit DUT (.mclk(mclk), .rst(rst), .regReq(regReq),
    .regWrite(regWrite), .regNum(regNum), .regWrData(regWrData),
    .regRdData(regRdData), .regDone(regDone), .faultGp(faultGp),
    .faultUd(faultUd), .mode64(mode64), .privRing(privRing),
    .debugExtOn(debugExtOn), .refValid(refValid), .refKind(refKind),
    .refAddr(refAddr), .refSize(refSize), .stepEvent(evt[0]),
    .taskSwitch(evt[1]), .taskTrapBit(evt[2]), .handlerEntry(evt[3]),
    .debugTrapReq(debugTrapReq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic mv(logic w, logic [2:0] n, logic [63:0] d);
    @(posedge mclk);
    #1;
    regReq = 1'b1;
    regWrite = w;
    regNum = n;
    regWrData = d;
    @(posedge mclk);
    #1;
    regReq = 1'b0;
    dn = regDone;
    rd = regRdData;
    gp = faultGp;
    ud = faultUd;
    chk("regDone", 64'(dn), 64'h1);
  endtask : mv

  task automatic rdv(logic [2:0] n, logic [63:0] exp);
    mv(1'b0, n, 64'h0);
    chk("read data", rd, exp);
  endtask : rdv

  task automatic hit(bdr_kind_e k, logic [63:0] a, logic [3:0] s,
                     logic [3:0] e, int exp);
    int c0;
    c0 = core.trapCount;
    core.issue(k, a, s, e);
    chk("trap count", 64'(core.trapCount - c0), 64'(exp));
  endtask : hit

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rdv(3'h6, 64'hFFFF0FF0);
    rdv(3'h7, 64'h400);
    mv(1'b1, 3'h1, 64'h8000123456789ABC);
    rdv(3'h1, 64'h8000123456789ABC);
    mode64 = 1'b0;
    mv(1'b1, 3'h2, 64'hFFFFFFFF12345678);
    rdv(3'h1, 64'h56789ABC);
    mode64 = 1'b1;
    rdv(3'h2, 64'h12345678);
    mv(1'b1, 3'h7, 64'h100000000);
    chk("gp upper control", 64'(gp), 64'h1);
    mv(1'b1, 3'h6, 64'h100000000);
    chk("gp upper status", 64'(gp), 64'h1);
    mv(1'b1, 3'h7, 64'hFFFFDFFF);
    rdv(3'h7, 64'hFFFF07FF);
    mv(1'b1, 3'h7, 64'h0);
    $display("test regs done");
  endtask : t_regs

  task automatic t_access();
    privRing = 2'h3;
    mv(1'b1, 3'h0, 64'h55);
    chk("gp ring", 64'(gp), 64'h1);
    privRing = 2'h0;
    rdv(3'h0, 64'h0);
    debugExtOn = 1'b1;
    mv(1'b0, 3'h4, 64'h0);
    chk("ud alias", 64'(ud), 64'h1);
    debugExtOn = 1'b0;
    mv(1'b1, 3'h5, 64'h2);
    rdv(3'h7, 64'h402);
    rdv(3'h4, 64'hFFFF0FF0);
    mv(1'b1, 3'h7, 64'h0);
    $display("test access done");
  endtask : t_access

  task automatic t_match();
    logic [1:0] ty;
    mv(1'b1, 3'h2, 64'hF000);
    mv(1'b1, 3'h7, 64'h3000010);
    hit(BDR_K_READ, 64'hEFFE, 4'h4, 4'h0, 1);
    rdv(3'h6, 64'hFFFF0FF4);
    hit(BDR_K_READ, 64'hEFFE, 4'h2, 4'h0, 0);
    for (int i = 0; i < 8; i++) begin
      ty = 2'(i / 2);
      debugExtOn = (i == 4);
      mv(1'b1, 3'h7, 64'h10 | (64'(ty) << 24));
      hit(kTab[i], 64'hF000, 4'h1, 4'h0,
          int'(i % 2 == 0 || i == 7));
    end
    debugExtOn = 1'b0;
    mv(1'b1, 3'h0, 64'h1000);
    for (int c = 0; c < 4; c++) begin
      mv(1'b1, 3'h7, 64'h30001 | (64'(c) << 18));
      hit(BDR_K_READ, 64'h1000 | mTab[c], 4'h1, 4'h0, 1);
      hit(BDR_K_READ, 64'h1001 + mTab[c], 4'h1, 4'h0, 0);
    end
    for (int s = 0; s < 4; s++) begin
      mv(1'b1, 3'(s), 64'h100 * (s + 1));
      mv(1'b1, 3'h7, (64'h2 << (2 * s)) | (64'h3 << (16 + 4 * s)));
      hit(BDR_K_WRITE, 64'h100 * (s + 1), 4'h1, 4'h0, 1);
      rdv(3'h6, 64'hFFFF0FF0 | (64'h1 << s));
    end
    $display("test match done");
  endtask : t_match

  task automatic t_events();
    mv(1'b1, 3'h6, 64'h0);
    mv(1'b1, 3'h7, 64'hFF);
    hit(BDR_K_READ, 64'h0, 4'h0, 4'h2, 0);
    rdv(3'h7, 64'h4AA);
    mv(1'b1, 3'h7, 64'hFF);
    hit(BDR_K_READ, 64'h0, 4'h0, 4'h6, 1);
    mv(1'b0, 3'h6, 64'h0);
    chk("task flag", 64'(rd[15]), 64'h1);
    hit(BDR_K_FETCH, 64'h400, 4'h1, 4'h1, 1);
    rdv(3'h6, 64'hFFFFCFF8);
    mv(1'b1, 3'h6, 64'h0);
    mv(1'b1, 3'h7, 64'h2000);
    hit(BDR_K_READ, 64'h0, 4'h0, 4'h0, 0);
    mv(1'b1, 3'h0, 64'h77);
    chk("guard read data", rd, 64'h0);
    hit(BDR_K_READ, 64'h0, 4'h0, 4'h8, 1);
    rdv(3'h7, 64'h400);
    rdv(3'h0, 64'h100);
    hit(BDR_K_READ, 64'h0, 4'h0, 4'h1, 1);
    mv(1'b0, 3'h6, 64'h0);
    chk("guard flag", 64'(rd[13]), 64'h1);
    $display("test events done");
  endtask : t_events

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    #20000;
    mismatches++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_regs();
    t_access();
    t_match();
    t_events();
    summarize();
  end
endmodule : test_breakpoint_debug_register_unit
`default_nettype wire
